// ### verilog/bid_ctrl_pkg.sv
package bid_ctrl_pkg;
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned STAGE_MS        = 500;
    localparam int unsigned STAGE_CYCLES    = (CLK_HZ / 1000) * STAGE_MS;
    localparam int unsigned POWERUP_MS      = 80;
    localparam int unsigned POWERUP_CYCLES  = (CLK_HZ / 1000) * POWERUP_MS;
    localparam int unsigned DEBOUNCE_MS     = 5;
    localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int unsigned CNT_W           = 25;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_STAGE1 = 4'b0010,
        ST_STAGE2 = 4'b0100,
        ST_DONE   = 4'b1000
    } delay_state_t;
endpackage : bid_ctrl_pkg

// ### verilog/tape_reader_bid.sv
// Function
// - request allowed only while tape is loaded
// - debounced request switch toggles request once
// - request set starts motors, lights lamps
// - motor switch runs motors without request lamp
// - first delay stage then identical second stage
// - delayed request sets after one second total
// - line request needs both request flip-flops
// - second press before grant cancels request
// - press ignored for reset once granted
// - under grant only tape-out clears request
// - tape-out clears only off-line or header done
// - stop while on-line reading blocks tape-out
// - power-up delay clears request flip-flops
// - skip press sets skip only when not granted
// - skip request drives skip relay and lamp
// - skip at request set sets skip mode
// - tape-out also clears skip request
// - no skip at request set clears mode
// - header done under grant clears skip mode
`timescale 1ns/1ps
`default_nettype none
module tape_reader_bid
    import bid_ctrl_pkg::*;
#(
    parameter int unsigned STAGE_CNT    = STAGE_CYCLES,
    parameter int unsigned POWERUP_CNT  = POWERUP_CYCLES,
    parameter int unsigned DEBOUNCE_CNT = DEBOUNCE_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic tape_out_closed,
    input  wire logic request_switch,
    input  wire logic motor_switch,
    input  wire logic skip_switch,
    input  wire logic stop_switch,
    input  wire logic line_grant,
    input  wire logic header_done,
    output logic      motor_start_relay,
    output logic      request_indicator_relay,
    output logic      request_lamp,
    output logic      motor_lamp,
    output logic      skip_indicator_relay,
    output logic      skip_lamp,
    output logic      line_request,
    output logic      skip_mode
);
    import bid_ctrl_pkg::*;

    typedef struct packed {
        logic              req_prev;
        logic              skip_prev;
        logic              tape_prev;
        logic              hdr_prev;
        logic [CNT_W-1:0]  pwr_cnt;
        logic              pwr_done;
        logic              bid;
        logic              bid_delayed;
        delay_state_t      dly_state;
        logic [CNT_W-1:0]  dly_cnt;
        logic              skip_req;
        logic              skip_mode;
        logic              motor_run;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic req_press;
    logic skip_press;
    logic tape_loaded;
    logic tape_out_edge;
    logic hdr_edge;
    logic tape_out_ok;
    logic bid_set;
    logic bid_clr;
    logic [CNT_W-1:0] stage_last;
    logic [CNT_W-1:0] pwr_last;
    logic             tape_lvl;
    logic             req_lvl;
    logic             mot_lvl;
    logic             skip_lvl;
    logic             stop_lvl;
    logic             grant_lvl;
    logic             hdr_lvl;

    assign stage_last = CNT_W'(STAGE_CNT - 1);
    assign pwr_last   = CNT_W'(POWERUP_CNT - 1);

    // every switch and contact passes two flip-flops and a hold filter
    contact_filter #(
        .CNT_W    (CNT_W),
        .HOLD_CNT (1)
    ) u_tape_filter (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .raw_in  (tape_out_closed),
        .level   (tape_lvl)
    );

    // both push switches are latched against contact bounce
    contact_filter #(
        .CNT_W    (CNT_W),
        .HOLD_CNT (DEBOUNCE_CNT)
    ) u_req_filter (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .raw_in  (request_switch),
        .level   (req_lvl)
    );

    contact_filter #(
        .CNT_W    (CNT_W),
        .HOLD_CNT (DEBOUNCE_CNT)
    ) u_skip_filter (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .raw_in  (skip_switch),
        .level   (skip_lvl)
    );

    contact_filter #(
        .CNT_W    (CNT_W),
        .HOLD_CNT (1)
    ) u_mot_filter (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .raw_in  (motor_switch),
        .level   (mot_lvl)
    );

    contact_filter #(
        .CNT_W    (CNT_W),
        .HOLD_CNT (1)
    ) u_stop_filter (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .raw_in  (stop_switch),
        .level   (stop_lvl)
    );

    contact_filter #(
        .CNT_W    (CNT_W),
        .HOLD_CNT (1)
    ) u_grant_filter (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .raw_in  (line_grant),
        .level   (grant_lvl)
    );

    contact_filter #(
        .CNT_W    (CNT_W),
        .HOLD_CNT (1)
    ) u_hdr_filter (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .raw_in  (header_done),
        .level   (hdr_lvl)
    );

    always_comb begin
        st_nxt = st_r;
        // one press gives one rising edge of the filtered level
        st_nxt.req_prev  = req_lvl;
        st_nxt.skip_prev = skip_lvl;
        req_press  = req_lvl & ~st_r.req_prev;
        skip_press = skip_lvl & ~st_r.skip_prev;

        st_nxt.tape_prev = tape_lvl;
        st_nxt.hdr_prev  = hdr_lvl;
        tape_loaded   = ~tape_lvl;
        tape_out_edge = tape_lvl & ~st_r.tape_prev;
        hdr_edge      = hdr_lvl & ~st_r.hdr_prev;

        // tape-out honoured off-line or after header, never on stop while granted
        tape_out_ok = tape_out_edge
                    & (~grant_lvl | ~st_r.skip_mode & hdr_lvl | hdr_edge)
                    & ~(stop_lvl & grant_lvl);

        // press toggles: set if tape loaded, cancel only before grant
        bid_set = req_press & ~st_r.bid & tape_loaded;
        bid_clr = (req_press & st_r.bid & ~grant_lvl) | tape_out_ok;

        if (!st_r.pwr_done) begin
            if (st_r.pwr_cnt == pwr_last) begin
                st_nxt.pwr_done = 1'b1;
            end else begin
                st_nxt.pwr_cnt = st_r.pwr_cnt + 1'b1;
            end
        end

        // two cascaded stage timers
        case (st_r.dly_state)
            ST_IDLE: begin
                st_nxt.dly_cnt = '0;
                if (bid_set) begin
                    st_nxt.dly_state = ST_STAGE1;
                end
            end
            ST_STAGE1: begin
                if (st_r.dly_cnt == stage_last) begin
                    st_nxt.dly_cnt   = '0;
                    st_nxt.dly_state = ST_STAGE2;
                end else begin
                    st_nxt.dly_cnt = st_r.dly_cnt + 1'b1;
                end
            end
            ST_STAGE2: begin
                if (st_r.dly_cnt == stage_last) begin
                    st_nxt.dly_cnt   = '0;
                    st_nxt.dly_state = ST_DONE;
                    st_nxt.bid_delayed = st_r.bid;
                end else begin
                    st_nxt.dly_cnt = st_r.dly_cnt + 1'b1;
                end
            end
            ST_DONE: begin
                st_nxt.dly_cnt = '0;
            end
            default: begin
                st_nxt.dly_state = ST_IDLE;
                st_nxt.dly_cnt   = '0;
            end
        endcase

        if (bid_set) begin
            st_nxt.bid = 1'b1;
            // skip mode decided at request set
            st_nxt.skip_mode = st_r.skip_req;
        end
        if (bid_clr) begin
            st_nxt.bid         = 1'b0;
            st_nxt.bid_delayed = 1'b0;
            st_nxt.dly_state   = ST_IDLE;
            st_nxt.dly_cnt     = '0;
        end

        // header complete under grant routes steps to reader
        if (hdr_edge && grant_lvl) begin
            st_nxt.skip_mode = 1'b0;
        end

        // skip request: press ignored while granted
        if (tape_out_ok) begin
            st_nxt.skip_req = 1'b0;
        end else if (skip_press && !grant_lvl) begin
            st_nxt.skip_req = 1'b1;
        end

        st_nxt.motor_run = st_nxt.bid | mot_lvl;

        // power-up clear of the request flip-flops
        if (!st_r.pwr_done) begin
            st_nxt.bid         = 1'b0;
            st_nxt.bid_delayed = 1'b0;
            st_nxt.dly_state   = ST_IDLE;
            st_nxt.skip_mode   = 1'b0;
            st_nxt.motor_run   = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r           <= '0;
            st_r.dly_state <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign motor_start_relay       = st_r.motor_run;
    assign request_indicator_relay = st_r.bid;
    assign request_lamp            = st_r.bid;
    assign motor_lamp              = st_r.bid;
    assign line_request            = st_r.bid & st_r.bid_delayed;
    assign skip_indicator_relay    = st_r.skip_req;
    assign skip_lamp               = st_r.skip_req;
    assign skip_mode               = st_r.skip_mode;
endmodule : tape_reader_bid

// two-flop synchroniser followed by a hold-time filter
module contact_filter #(
    parameter int unsigned CNT_W    = 25,
    parameter int unsigned HOLD_CNT = 1
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic raw_in,
    output logic      level
);
    typedef struct packed {
        logic [1:0]       sync;
        logic             level;
        logic [CNT_W-1:0] cnt;
    } filt_state_t;

    filt_state_t      fs_r;
    filt_state_t      fs_nxt;
    logic [CNT_W-1:0] hold_last;

    assign hold_last = CNT_W'(HOLD_CNT - 1);

    always_comb begin
        fs_nxt      = fs_r;
        fs_nxt.sync = {fs_r.sync[0], raw_in};
        // a new level is taken only after it has held HOLD_CNT cycles
        if (fs_r.sync[1] == fs_r.level) begin
            fs_nxt.cnt = '0;
        end else if (fs_r.cnt == hold_last) begin
            fs_nxt.level = fs_r.sync[1];
            fs_nxt.cnt   = '0;
        end else begin
            fs_nxt.cnt = fs_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fs_r <= '0;
        end else begin
            fs_r <= fs_nxt;
        end
    end

    assign level = fs_r.level;
endmodule : contact_filter
`default_nettype wire

// ### bench/tape_reader_bid_props.sv
`timescale 1ns/1ps
`default_nettype none
module tape_reader_bid_props (
    input wire logic sys_clk, reset_n, tape_out_closed, request_switch, motor_switch,
    input wire logic skip_switch, stop_switch, line_grant, header_done,
    input wire logic motor_start_relay, request_indicator_relay, request_lamp, motor_lamp,
    input wire logic skip_indicator_relay, skip_lamp, line_request, skip_mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_both; line_request |-> request_lamp; endproperty
    a_both: assert property (p_both) else $error("line request alone");
    property p_lamps; request_lamp == motor_lamp && request_lamp == request_indicator_relay
        && (!request_lamp || motor_start_relay); endproperty
    a_lamps: assert property (p_lamps) else $error("lamp mismatch");
    property p_delay; $rose(request_lamp) |-> !line_request [*8]; endproperty
    a_delay: assert property (p_delay) else $error("line request early");
    property p_skl; skip_lamp == skip_indicator_relay; endproperty
    a_skl: assert property (p_skl) else $error("skip lamp mismatch");
    property p_tout; (tape_out_closed && !line_grant) [*6] |-> !request_lamp && !skip_lamp;
    endproperty
    a_tout: assert property (p_tout) else $error("tape out not cleared");
    property p_hold; (line_grant && !header_done) [*5] ##0 request_lamp |=> request_lamp;
    endproperty
    a_hold: assert property (p_hold) else $error("request lost");
    property p_sgr; line_grant [*5] ##0 !skip_lamp |=> !skip_lamp; endproperty
    a_sgr: assert property (p_sgr) else $error("skip set under grant");
    property p_mode; $rose(request_lamp) |-> ##[0:1] skip_mode == skip_lamp; endproperty
    a_mode: assert property (p_mode) else $error("skip mode wrong");
    property p_hdr; (line_grant && header_done) [*5] |-> !skip_mode; endproperty
    a_hdr: assert property (p_hdr) else $error("skip mode held");
    c_line: cover property ($rose(line_request));
    c_grant: cover property (line_grant && request_lamp);
    c_skip: cover property ($rose(skip_mode));
endmodule : tape_reader_bid_props
bind tape_reader_bid tape_reader_bid_props u_tape_reader_bid_props (.*);
`default_nettype wire

// ### bench/seq_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module seq_ctrl_model #(
    parameter int LAT = 3,
    parameter int HDR = 40
) (
    input  wire logic sys_clk, reset_n, line_request, permit,
    output logic      line_grant, header_done
);
    int n;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            n <= 0;
            line_grant <= 1'b0;
            header_done <= 1'b0;
        end else begin
            n <= (line_request && permit) ? n + 1 : 0;
            line_grant <= line_request && permit && n >= LAT;
            header_done <= line_grant && n >= LAT + HDR;
        end
    end
endmodule : seq_ctrl_model
`default_nettype wire

// ### bench/tb_tape_reader_bid.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tape_reader_bid;
    logic sys_clk = 0, reset_n = 0, tape_out_closed = 1, motor_switch = 0, stop_switch = 0;
    logic request_switch = 0, skip_switch = 0, permit = 0;
    logic line_grant, header_done, motor_start_relay, request_indicator_relay, request_lamp;
    logic motor_lamp, skip_indicator_relay, skip_lamp, line_request, skip_mode;
    int   n_fail = 0, n_compared = 0, w;
    initial forever #12.5 sys_clk = ~sys_clk;
    tape_reader_bid #(.STAGE_CNT(10), .POWERUP_CNT(4), .DEBOUNCE_CNT(2)) u_tape_reader_bid (.*);
    seq_ctrl_model u_seq_ctrl_model (.*);
    task cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : cyc
    task conclude;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task chk(input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task press(input bit skip);
        if (skip) skip_switch = 1;
        else request_switch = 1;
        cyc(6);
        skip_switch = 0;
        request_switch = 0;
        cyc(6);
    endtask : press
    // bounded wait: 0 request, 1 line request, 2 grant, 3 header done
    task wt(input int k);
        w = 0;
        while ((k == 0 ? request_lamp : k == 1 ? line_request : k == 2 ? line_grant
                : header_done) !== 1'b1) begin
            w++;
            if (w > 80) begin
                n_fail++;
                conclude();
            end
            cyc(1);
        end
    endtask : wt
    initial begin
        cyc(10);
        reset_n = 1;
        cyc(12);
        chk({request_lamp, line_request, motor_start_relay}, 0);
        press(0); chk(request_lamp, 0);
        tape_out_closed = 0;
        cyc(5);
        request_switch = 1;
        wt(0);
        request_switch = 0;
        chk({motor_start_relay, request_indicator_relay, motor_lamp, skip_mode}, 8'h0e);
        wt(1); chk(w inside {20, 21}, 1);
        press(0); chk({request_lamp, line_request}, 0);
        motor_switch = 1;
        cyc(5);
        chk({motor_start_relay, request_lamp, motor_lamp}, 8'h04);
        motor_switch = 0;
        $display("test bid and cancel done");
        press(1); chk({skip_lamp, skip_indicator_relay}, 8'h03);
        press(0); chk(skip_mode, 1);
        permit = 1;
        wt(2);
        press(0); chk(request_lamp, 1);
        tape_out_closed = 1;
        cyc(4);
        tape_out_closed = 0;
        cyc(4); chk(request_lamp, 1);
        wt(3);
        cyc(4); chk(skip_mode, 0);
        stop_switch = 1;
        cyc(3);
        tape_out_closed = 1;
        cyc(6); chk(request_lamp, 1);
        tape_out_closed = 0;
        stop_switch = 0;
        cyc(4);
        tape_out_closed = 1;
        cyc(6); chk({request_lamp, line_request, skip_lamp, motor_start_relay}, 0);
        $display("test skip and tape out done");
        tape_out_closed = 0;
        cyc(5);
        press(1); press(0); press(0); // skip mode set, request cancelled before grant
        tape_out_closed = 1;
        cyc(6); chk(skip_lamp, 0);
        tape_out_closed = 0;
        cyc(5); chk(skip_mode, 1);
        press(0); chk(skip_mode, 0);
        wt(2);
        press(1); chk(skip_lamp, 0);
        $display("test skip under grant done");
        conclude();
    end
endmodule : tb_tape_reader_bid
`default_nettype wire
